// >>> design/csq_pkg.sv
// Purpose: Shared constants for the cipher sequencer conditional-op decoder
// Assumes: 200 MHz reference clock, 22-bit microinstructions
// Notes: Instruction word packs M1 in [21:14], M2 in [13:6], M3 in [5:0]
// =============================================================
// Constants
// =============================================================
package csq_pkg;
  // Reference clock period
  localparam int REF_PERIOD_NS = 5;
  // Fastest sequencer clock period (8 MHz)
  localparam int SEQ_PERIOD_MIN_NS = 125;
  // Slowest sequencer clock period (10 kHz)
  localparam int SEQ_PERIOD_MAX_NS = 100000;
  // Fastest serial key clock period (1.6 MHz)
  localparam int KEY_CLK_PERIOD_MIN_NS = 625;
  // Least reference cycles between two serial key falling edges
  localparam int KEY_CLK_MIN_CYC = (KEY_CLK_PERIOD_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  // Sequencer clock periods from key request to first key clock fall
  localparam int KEY_REQ_WAIT_SEQ = 4;
  // Word and memory geometry
  localparam int INSTR_W = 22;
  localparam int ADDR_W = 6;
  localparam int ROM_WORDS = 29;
  localparam int RAM_WORDS = 32;
  localparam logic [5:0] RAM_BASE = 6'h20;
  localparam int KEY_BITS = 64;
  // Field positions inside the instruction word
  localparam int M1_LSB = 14;
  localparam int M2_LSB = 6;
  localparam int M2_CLK_SEL = 10;
  // Entry points in the fixed store
  localparam logic [5:0] ENT_CORE = 6'h00;
  localparam logic [5:0] ENT_IV_LOAD = 6'h06;
  localparam logic [5:0] ENT_KEY_PAR = 6'h0B;
  localparam logic [5:0] ENT_KEY_SER = 6'h10;
  localparam logic [5:0] ENT_ECB = 6'h12;
  // Conditional operation codes (low nibble of M2)
  typedef enum logic [3:0] {
    OP_LOAD_LOOP = 4'h0, OP_DEC_LOOP = 4'h1, OP_CALL = 4'h2, OP_RETURN = 4'h3,
    OP_JUMP = 4'h4, OP_IF_IN_EMPTY = 4'h5, OP_IF_OUT_FULL = 4'h6, OP_IF_READY = 4'h7,
    OP_IF_ORDER_LOW = 4'h8, OP_ROTATE_DIR = 4'h9, OP_PAIR_ADDR = 4'hA, OP_SETUP = 4'hB,
    OP_CLEAR = 4'hC, OP_SPARE_D = 4'hD, OP_SPARE_E = 4'hE, OP_STEP_NEXT = 4'hF
  } csq_op_t;
  // Argument bit positions in M3
  localparam int ARG_ROT_RIGHT = 0;
  localparam int ARG_PAIR_HI = 2;
  localparam int ARG_PAIR_LO = 1;
  localparam int ARG_INTERNAL = 0;
  localparam int ARG_FORCE_FLAGS = 5;
  localparam int ARG_BYTE_FB = 4;
  localparam int ARG_BIT_FB = 3;
  localparam int ARG_SERIAL = 2;
  localparam int ARG_MASTER = 1;
  localparam int ARG_ACTIVE = 0;
  // Clock command bit positions (M1 bit0, M2 bit7)
  localparam int CMD_CLR_IN_FULL = M1_LSB;
  localparam int CMD_CLR_OUT_EMPTY = M2_LSB + 7;
  // Feedback width encodings {byte, bit}
  localparam logic [1:0] FB_64 = 2'h0;
  localparam logic [1:0] FB_8 = 2'h2;
  localparam logic [1:0] FB_1 = 2'h1;
  // Default fill word: unconditional step
  localparam logic [21:0] STEP_WORD = 22'h0003CF;
  // Sequencer phases
  typedef enum logic [1:0] {PH_IDLE, PH_FETCH, PH_EXEC} csq_phase_t;
endpackage : csq_pkg

// >>> design/csq_sequencer.sv
// Purpose: Microprogram sequencer and conditional-op decoder of a cipher processor
// Assumes: All inputs synchronous to i_ref_clk; host loads the writable store
// Notes: Sequencer clock is an enable divided from the reference clock
// Operation
// - Low nibble of M2 selects conditional op
// - One instruction every two sequencer clocks
// - Step op simply advances program counter
// - Rotate op latches right or left
// - Pair op latches two-bit pair selector
// - Internal bit picks latched or status pair
// - Setup bit5 forces input-full, output-empty flags
// - Setup bits4,3 select feedback width
// - Setup bit2 selects serial key entry
// - Setup bit1 forces master port input
// - Setup bit0 sets active flag and pin
// - Clear op resets all control latches
// - Fixed store 29 words at 00-1C
// - Writable store 32 words at 20-3F
// - Fixed store holds documented entry points
// - Clock rates bounded; key clock limited
// - Three nonoverlapping internal phases per instruction
// - New input accepted only after clear cmd
// - Return and clear ignore third byte
`timescale 1ns/1ps
module csq_sequencer
  import csq_pkg::*;
#(
  parameter int SEQ_PERIOD_NS = SEQ_PERIOD_MIN_NS,
  parameter logic [ROM_WORDS*INSTR_W-1:0] ROM_IMAGE = {ROM_WORDS{STEP_WORD}}
)(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic i_start,
  input wire logic [ADDR_W-1:0] i_start_addr,
  input wire logic i_mem_we,
  input wire logic [4:0] i_mem_addr,
  input wire logic [INSTR_W-1:0] i_mem_data,
  input wire logic i_in_write,
  input wire logic i_out_read,
  input wire logic [1:0] i_status_pair,
  input wire logic i_port_cfg_master,
  input wire logic i_key_order_bit,
  input wire logic i_key_serial_clock,
  input wire logic i_key_serial_data,
  output logic [ADDR_W-1:0] o_pc,
  output logic o_phase_pc,
  output logic o_phase_m,
  output logic o_phase_s,
  output logic [10:0] o_clock_cmd,
  output logic [10:0] o_mux_setting,
  output logic o_rotate_right,
  output logic o_rotate_left,
  output logic [1:0] o_pair_sel,
  output logic o_internal_addr,
  output logic [1:0] o_pair_effective,
  output logic o_byte_feedback,
  output logic o_bit_feedback,
  output logic o_feedback_illegal,
  output logic o_serial_key,
  output logic o_master_port_force,
  output logic o_input_from_master,
  output logic o_active,
  output logic o_input_full,
  output logic o_output_empty,
  output logic [3:0] o_loop_count,
  output logic o_key_request,
  output logic o_key_early,
  output logic o_key_clock_fast,
  output logic o_key_valid,
  output logic [KEY_BITS-1:0] o_key_data
);
  // =============================================================
  // Timing
  // =============================================================
  // Reference cycles per sequencer clock, longest period rounds down
  localparam int SEQ_DIV_CYC = (SEQ_PERIOD_NS / REF_PERIOD_NS < 1) ? 1 :
                               SEQ_PERIOD_NS / REF_PERIOD_NS;
  localparam int DIV_W = $clog2(SEQ_DIV_CYC + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEQ_DIV_CYC - 1);
  localparam logic [7:0] KEY_FAST_LIM = 8'(KEY_CLK_MIN_CYC);
  localparam logic [2:0] KEY_WAIT_LIM = 3'(KEY_REQ_WAIT_SEQ);
  localparam logic [6:0] KEY_LAST = 7'(KEY_BITS - 1);

  // =============================================================
  // Storage
  // =============================================================
  // Writable program store
  logic [INSTR_W-1:0] ram_mem [RAM_WORDS];
  // Instruction fetch from fixed or writable store
  function automatic logic [INSTR_W-1:0] fetch_word(input logic [ADDR_W-1:0] a);
    logic [INSTR_W-1:0] w;
    w = STEP_WORD;
    if (a >= RAM_BASE)
      w = ram_mem[a[4:0]];
    else if (int'(a) < ROM_WORDS)
      w = ROM_IMAGE[int'(a)*INSTR_W +: INSTR_W];
    return w;
  endfunction : fetch_word

  // =============================================================
  // State
  // =============================================================
  logic [DIV_W-1:0] div_r; // Sequencer clock divider
  logic seq_tick; // One-cycle sequencer clock enable
  csq_phase_t phase_r; // Instruction half
  logic s_pend_r; // Late phase pending
  logic [ADDR_W-1:0] pc_r; // Program counter
  logic [ADDR_W-1:0] ret_r; // Single-level return address
  logic [INSTR_W-1:0] ir_r; // Fetched instruction
  logic [3:0] loop_r; // Loop counter
  logic rot_r_r, rot_l_r, int_r, byte_r, bit_r, ser_r, mst_r, act_r;
  logic [1:0] pair_r;
  logic in_full_r, out_empty_r;
  logic [10:0] clk_cmd_r, mux_r;
  logic phase_pc_r, phase_m_r, phase_s_r;

  // =============================================================
  // Decode
  // =============================================================
  wire [7:0] m1 = ir_r[INSTR_W-1:M1_LSB];
  wire [7:0] m2 = ir_r[M1_LSB-1:M2_LSB];
  wire [5:0] m3 = ir_r[M2_LSB-1:0];
  wire [3:0] op_code = m2[3:0];
  wire is_clk_cmd = ir_r[M2_CLK_SEL];
  wire exec = seq_tick && (phase_r == PH_EXEC);
  wire fetch = seq_tick && (phase_r == PH_FETCH);
  wire [ADDR_W-1:0] pc_inc = pc_r + 6'h01;
  wire [3:0] loop_dec = loop_r - 4'h1;
  wire op_rot = exec && (op_code == OP_ROTATE_DIR);
  wire op_pair = exec && (op_code == OP_PAIR_ADDR);
  wire op_setup = exec && (op_code == OP_SETUP);
  wire op_clear = exec && (op_code == OP_CLEAR);
  wire clr_in = exec && is_clk_cmd && ir_r[CMD_CLR_IN_FULL];
  wire clr_out = exec && is_clk_cmd && ir_r[CMD_CLR_OUT_EMPTY];
  wire force_flags = op_setup && m3[ARG_FORCE_FLAGS];

  // Next program counter, M3 used as target by jump, call and taken branches; return uses saved address, others increment
  logic [ADDR_W-1:0] pc_nxt;
  always_comb
  begin
    pc_nxt = pc_inc;
    case (op_code)
      OP_DEC_LOOP: if (loop_dec != 4'h0) pc_nxt = m3;
      OP_CALL: pc_nxt = m3;
      OP_RETURN: pc_nxt = ret_r;
      OP_JUMP: pc_nxt = m3;
      OP_IF_IN_EMPTY: if (!in_full_r) pc_nxt = m3;
      OP_IF_OUT_FULL: if (!out_empty_r) pc_nxt = m3;
      OP_IF_READY: if (in_full_r && out_empty_r) pc_nxt = m3;
      OP_IF_ORDER_LOW: if (!i_key_order_bit) pc_nxt = m3;
      OP_STEP_NEXT: pc_nxt = pc_inc;
      OP_SPARE_D, OP_SPARE_E: pc_nxt = pc_inc;
      default: pc_nxt = pc_inc;
    endcase
  end

  // =============================================================
  // Sequencer clock and phases
  // =============================================================
  assign seq_tick = i_run && (div_r == DIV_LAST);

  // Divider for the sequencer clock enable
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n || !i_run || div_r == DIV_LAST)
      div_r <= '0;
    else
      div_r <= div_r + DIV_W'(1);
  end

  // Fetch then execute, pc, m and s phases on distinct cycles
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      phase_r <= PH_IDLE;
      pc_r <= ENT_CORE;
      ir_r <= STEP_WORD;
      phase_pc_r <= 1'b0;
      phase_m_r <= 1'b0;
      phase_s_r <= 1'b0;
      s_pend_r <= 1'b0;
    end
    else
    begin
      phase_pc_r <= fetch;
      phase_m_r <= exec;
      s_pend_r <= phase_m_r;
      phase_s_r <= s_pend_r;
      if (i_start)
      begin
        // Host launches the program at an entry point
        pc_r <= i_start_addr;
        phase_r <= PH_FETCH;
      end
      else if (fetch)
      begin
        ir_r <= fetch_word(pc_r);
        phase_r <= PH_EXEC;
      end
      else if (exec)
      begin
        pc_r <= pc_nxt;
        phase_r <= PH_FETCH;
      end
    end
  end

  // Writable store load port
  always_ff @(posedge i_ref_clk)
  begin
    if (i_mem_we)
      ram_mem[i_mem_addr] <= i_mem_data;
  end

  // Return address and loop counter
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      ret_r <= ENT_CORE;
      loop_r <= 4'h0;
    end
    else if (exec)
    begin
      if (op_code == OP_CALL)
        ret_r <= pc_inc;
      if (op_code == OP_LOAD_LOOP)
        loop_r <= m3[3:0];
      else if (op_code == OP_DEC_LOOP)
        loop_r <= loop_dec;
    end
  end

  // Clock command and multiplexer setting outputs
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      clk_cmd_r <= '0;
      mux_r <= '0;
    end
    else
    begin
      clk_cmd_r <= (exec && is_clk_cmd) ? {m1, m2[7:5]} : 11'h000;
      if (exec && !is_clk_cmd)
        mux_r <= {m1, m2[7:5]};
    end
  end

  // =============================================================
  // Control latches
  // =============================================================
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      {rot_r_r, rot_l_r, int_r, byte_r, bit_r, ser_r, mst_r, act_r} <= 8'h00;
      pair_r <= 2'h0;
    end
    else if (op_clear)
    begin
      // Clear all latched control
      {rot_r_r, rot_l_r, int_r, byte_r, bit_r, ser_r, mst_r, act_r} <= 8'h00;
      pair_r <= 2'h0;
    end
    else if (op_rot)
    begin
      rot_r_r <= m3[ARG_ROT_RIGHT];
      rot_l_r <= !m3[ARG_ROT_RIGHT];
    end
    else if (op_pair)
    begin
      pair_r <= {m3[ARG_PAIR_HI], m3[ARG_PAIR_LO]};
      int_r <= m3[ARG_INTERNAL];
    end
    else if (op_setup)
    begin
      byte_r <= m3[ARG_BYTE_FB];
      bit_r <= m3[ARG_BIT_FB];
      ser_r <= m3[ARG_SERIAL];
      mst_r <= m3[ARG_MASTER];
      if (m3[ARG_ACTIVE])
        act_r <= 1'b1;
    end
  end

  // Data flags: forcing and host reads win over microprogram clears, host writes only while input not full
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      in_full_r <= 1'b0;
      out_empty_r <= 1'b1;
    end
    else
    begin
      if ((i_in_write && !in_full_r) || force_flags)
        in_full_r <= 1'b1;
      else if (clr_in)
        in_full_r <= 1'b0;
      if (i_out_read || force_flags)
        out_empty_r <= 1'b1;
      else if (clr_out)
        out_empty_r <= 1'b0;
    end
  end

  // =============================================================
  // Serial key loader
  // =============================================================
  logic key_clk_d_r; // Previous key clock sample
  logic [6:0] key_cnt_r; // Bits received
  logic [7:0] key_gap_r; // Cycles since last key clock fall
  logic [2:0] key_wait_r; // Sequencer clocks since request rose
  logic key_valid_r;
  logic [KEY_BITS-1:0] key_sh_r;
  wire key_req = ser_r && !key_valid_r;
  wire key_fall = key_clk_d_r && !i_key_serial_clock;

  // Shift key bits on falling key clock and police its timing
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n || !ser_r)
    begin
      key_clk_d_r <= 1'b1;
      key_cnt_r <= 7'h00;
      key_gap_r <= KEY_FAST_LIM;
      key_wait_r <= 3'h0;
      key_valid_r <= 1'b0;
      key_sh_r <= '0;
      o_key_early <= 1'b0;
      o_key_clock_fast <= 1'b0;
    end
    else
    begin
      key_clk_d_r <= i_key_serial_clock;
      if (seq_tick && key_req && key_wait_r != KEY_WAIT_LIM)
        key_wait_r <= key_wait_r + 3'h1;
      if (key_fall && key_req)
      begin
        key_sh_r <= {key_sh_r[KEY_BITS-2:0], i_key_serial_data};
        key_cnt_r <= key_cnt_r + 7'h01;
        key_gap_r <= 8'h00;
        if (key_cnt_r == KEY_LAST)
          key_valid_r <= 1'b1;
        if (key_wait_r != KEY_WAIT_LIM)
          o_key_early <= 1'b1;
        if (key_gap_r < KEY_FAST_LIM)
          o_key_clock_fast <= 1'b1;
      end
      else if (key_gap_r != KEY_FAST_LIM)
        key_gap_r <= key_gap_r + 8'h01;
    end
  end

  // =============================================================
  // Outputs
  // =============================================================
  assign o_pc = pc_r;
  assign o_phase_pc = phase_pc_r;
  assign o_phase_m = phase_m_r;
  assign o_phase_s = phase_s_r;
  assign o_clock_cmd = clk_cmd_r;
  assign o_mux_setting = mux_r;
  assign o_rotate_right = rot_r_r;
  assign o_rotate_left = rot_l_r;
  assign o_pair_sel = pair_r;
  assign o_internal_addr = int_r;
  assign o_pair_effective = int_r ? pair_r : i_status_pair;
  assign o_byte_feedback = byte_r;
  assign o_bit_feedback = bit_r;
  assign o_feedback_illegal = byte_r && bit_r;
  assign o_serial_key = ser_r;
  assign o_master_port_force = mst_r;
  assign o_input_from_master = mst_r || i_port_cfg_master;
  assign o_active = act_r;
  assign o_input_full = in_full_r;
  assign o_output_empty = out_empty_r;
  assign o_loop_count = loop_r;
  assign o_key_request = key_req;
  assign o_key_valid = key_valid_r;
  assign o_key_data = key_sh_r;
endmodule : csq_sequencer

// >>> test/csq_sequencer_monitor.sv
// Purpose: Port-level checker for the sequencer and conditional-op decoder
// Assumes: Default sequencer period (25 reference cycles a tick), i_run held high
// Notes: Bound to every csq_sequencer instance
`timescale 1ns/1ps
module csq_sequencer_monitor (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic i_start,
  input wire logic i_in_write,
  input wire logic [1:0] i_status_pair,
  input wire logic i_port_cfg_master,
  input wire logic o_phase_pc,
  input wire logic o_phase_m,
  input wire logic o_phase_s,
  input wire logic o_rotate_right,
  input wire logic o_rotate_left,
  input wire logic [1:0] o_pair_sel,
  input wire logic o_internal_addr,
  input wire logic [1:0] o_pair_effective,
  input wire logic o_byte_feedback,
  input wire logic o_bit_feedback,
  input wire logic o_feedback_illegal,
  input wire logic o_serial_key,
  input wire logic o_master_port_force,
  input wire logic o_input_from_master,
  input wire logic o_active,
  input wire logic o_input_full,
  input wire logic o_key_request
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  // ==========================================================
  // Helper: cycles since the last execute pulse
  // ==========================================================
  logic [6:0] gap_r;
  logic seen_r;
  // Gap counter, restarted by start, freeze or reset
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n || !i_run || i_start)
    begin
      gap_r <= 7'h00;
      seen_r <= 1'b0;
    end
    else if (o_phase_m)
    begin
      gap_r <= 7'h00;
      seen_r <= 1'b1;
    end
    else if (gap_r != 7'h7F)
    begin
      gap_r <= gap_r + 7'h01;
    end
  end
  // ==========================================================
  // Assertions
  // ==========================================================
  AST_EXEC_RATE: assert property (o_phase_m && seen_r |-> gap_r == 7'h31)
    else $error("execute pulses not two sequencer ticks apart");
  AST_PHASE_S: assert property (o_phase_m |-> ##2 o_phase_s)
    else $error("slave phase missing after execute");
  AST_FETCH_EXEC: assert property (o_phase_pc && i_run |-> ##25 o_phase_m)
    else $error("execute not one tick after fetch");
  AST_PHASE_SEP: assert property (!(o_phase_pc && (o_phase_m || o_phase_s)))
    else $error("phases overlap");
  AST_LATCH_HOLD: assert property (!o_phase_m |-> $stable({o_rotate_right, o_rotate_left,
    o_pair_sel, o_internal_addr, o_byte_feedback, o_bit_feedback, o_serial_key,
    o_master_port_force, o_active})) else $error("control latch moved outside execute");
  AST_FB_ILLEGAL: assert property (o_feedback_illegal == (o_byte_feedback && o_bit_feedback))
    else $error("illegal feedback flag wrong");
  AST_PAIR_EFF: assert property (o_pair_effective == (o_internal_addr ? o_pair_sel : i_status_pair))
    else $error("effective pair wrong");
  AST_MASTER_IN: assert property (o_input_from_master == (o_master_port_force || i_port_cfg_master))
    else $error("master input select wrong");
  AST_FULL_CLEAR: assert property ($fell(o_input_full) |-> o_phase_m)
    else $error("input full cleared outside execute");
  AST_FULL_SET: assert property (i_in_write && !o_input_full |=> o_input_full)
    else $error("host write did not set input full");
  AST_KEY_REQ: assert property (o_key_request |-> o_serial_key)
    else $error("key request outside serial mode");
  // Main scenarios reached
  cover property (o_phase_m && seen_r);
  cover property (o_feedback_illegal);
  cover property (o_key_request);
endmodule : csq_sequencer_monitor

bind csq_sequencer csq_sequencer_monitor csq_sequencer_monitor_i (.*);

// >>> test/csq_host_model.sv
// Purpose: Host and serial key source facing the sequencer
// Assumes: Default sequencer period; drives shortly after the rising edge
// Notes: Writes wait for input full to clear; key clock stands high between frames
`timescale 1ns/1ps
module csq_host_model
  import csq_pkg::*;
#(
  parameter logic [KEY_BITS-1:0] KEY_VALUE = 64'h0123_4567_89AB_CDEF
)(
  input wire logic i_ref_clk,
  input wire logic i_key_request,
  input wire logic i_input_full,
  input wire logic i_write_req,
  output logic o_in_write,
  output logic o_key_serial_clock,
  output logic o_key_serial_data
);
  // Half key period, full period above the fastest allowed
  localparam int HALF_CYC = (KEY_CLK_MIN_CYC + 1) / 2 + 2;
  // Wait after request, in reference cycles, with margin
  localparam int WAIT_CYC = KEY_REQ_WAIT_SEQ * SEQ_PERIOD_MIN_NS / REF_PERIOD_NS + 2;
  // ==========================================================
  // Serial key source: 64 bits, first bit first
  // ==========================================================
  initial
  begin
    o_key_serial_clock = 1'b1;
    o_key_serial_data = 1'b0;
    forever
    begin
      // Look at the request once the edge that launches it has settled
      @(posedge i_ref_clk);
      #1;
      if (i_key_request)
      begin
        repeat (WAIT_CYC) @(posedge i_ref_clk);
        for (int b = KEY_BITS - 1; b >= 0; b--)
        begin
          #1 o_key_serial_data = KEY_VALUE[b];
          repeat (HALF_CYC) @(posedge i_ref_clk);
          #1 o_key_serial_clock = 1'b0;
          repeat (HALF_CYC) @(posedge i_ref_clk);
          #1 o_key_serial_clock = 1'b1;
          // Released data shows the inverse of the last bit
          o_key_serial_data = ~KEY_VALUE[b];
        end
      end
    end
  end
  // ==========================================================
  // Host writes: only once the input word has been taken
  // ==========================================================
  initial
  begin
    o_in_write = 1'b0;
    forever
    begin
      @(posedge i_ref_clk);
      if (i_write_req)
      begin
        #1;
        while (i_input_full)
        begin
          @(posedge i_ref_clk);
          #1;
        end
        o_in_write = 1'b1;
        @(posedge i_ref_clk);
        #1 o_in_write = 1'b0;
      end
    end
  end
endmodule : csq_host_model

// >>> test/testbench.sv
// Purpose: Self-checking bench for the sequencer and conditional-op decoder
// Assumes: Default parameters; program runs from the writable store
// Notes: Rows hold a program word and the latch state expected after it
`timescale 1ns/1ps
module testbench
  import csq_pkg::*;
;
  // Row: word, then {right,left,pair[1:0],int,byte,bit,serial,master,active,full,empty}
  typedef struct packed {logic [21:0] word; logic [11:0] st;} csq_row_t;
  localparam int ROWS = 14;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  csq_row_t rows [ROWS] = '{
    '{{8'h00, 8'h0C, 6'h3F}, 12'h001}, '{{8'h00, 8'h09, 6'h01}, 12'h801},
    '{{8'h00, 8'h09, 6'h3E}, 12'h401}, '{{8'h00, 8'h0A, 6'h06}, 12'h701},
    '{{8'h00, 8'h0A, 6'h03}, 12'h581}, '{{8'h00, 8'h0B, 6'h1B}, 12'h5ED},
    '{{8'h01, 8'h9F, 6'h00}, 12'h5EC}, '{{8'h00, 8'h0B, 6'h20}, 12'h587},
    '{{8'h00, 8'h0D, 6'h3F}, 12'h587}, '{{8'h00, 8'h0E, 6'h3F}, 12'h587},
    '{{8'h00, 8'h0C, 6'h3F}, 12'h003}, '{{8'h00, 8'h0B, 6'h04}, 12'h013},
    '{{8'h00, 8'h00, 6'h05}, 12'h013}, '{{8'h1D, 8'h04, 6'h2D}, 12'h013}};
  logic i_ref_clk = 1'b0;
  logic i_reset_n, i_run, i_start, i_mem_we, i_in_write, i_port_cfg_master, write_req;
  logic i_out_read, i_key_order_bit, i_key_serial_clock, i_key_serial_data;
  logic [5:0] i_start_addr, o_pc;
  logic [4:0] i_mem_addr;
  logic [21:0] i_mem_data;
  logic [1:0] i_status_pair, o_pair_sel, o_pair_effective;
  logic o_phase_pc, o_phase_m, o_phase_s, o_rotate_right, o_rotate_left, o_internal_addr;
  logic o_byte_feedback, o_bit_feedback, o_feedback_illegal, o_serial_key, o_active;
  logic o_master_port_force, o_input_from_master, o_input_full, o_output_empty;
  logic o_key_request, o_key_early, o_key_clock_fast, o_key_valid;
  logic [10:0] o_clock_cmd, o_mux_setting;
  logic [3:0] o_loop_count;
  logic [63:0] o_key_data;
  int fails = 0;
  int samples_checked = 0;
  // Latch state seen at the ports, same order as a row
  wire [11:0] st_seen = {o_rotate_right, o_rotate_left, o_pair_sel, o_internal_addr,
    o_byte_feedback, o_bit_feedback, o_serial_key, o_master_port_force, o_active,
    o_input_full, o_output_empty};
  always #(REF_PERIOD_NS / 2.0) i_ref_clk = ~i_ref_clk;
  csq_sequencer csq_sequencer_i (.*);
  csq_host_model csq_host_model_i (.i_ref_clk(i_ref_clk), .i_key_request(o_key_request),
    .i_input_full(o_input_full), .i_write_req(write_req), .o_in_write(i_in_write),
    .o_key_serial_clock(i_key_serial_clock), .o_key_serial_data(i_key_serial_data));
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Wait for key valid or an execute pulse under a bound, just after an edge
  task automatic wait_flag(input bit want_key, input int limit);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    #1;
    while ((want_key ? o_key_valid : o_phase_m) !== 1'b1 && n < limit)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (n >= limit)
    begin
      fails++;
    end
  endtask : wait_flag
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  // Watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge i_ref_clk);
    fails++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    i_reset_n = 1'b0;
    {i_run, i_start, i_mem_we, i_port_cfg_master, write_req, i_out_read} = 6'h20;
    i_key_order_bit = 1'b0;
    i_start_addr = RAM_BASE;
    i_mem_addr = 5'h00;
    i_mem_data = 22'h000000;
    i_status_pair = 2'h2;
    repeat (16) @(posedge i_ref_clk);
    #1 i_reset_n = 1'b1;
    check({o_pc, st_seen}, {6'h00, 12'h001});
    // Load program into the writable store, then run it
    for (int r = 0; r < ROWS; r++)
    begin
      i_mem_we = 1'b1;
      i_mem_addr = 5'(r);
      i_mem_data = rows[r].word;
      @(posedge i_ref_clk);
      #1;
    end
    i_mem_we = 1'b0;
    i_start = 1'b1;
    @(posedge i_ref_clk);
    #1 i_start = 1'b0;
    for (int r = 0; r < ROWS; r++)
    begin
      wait_flag(1'b0, 200);
      check({o_pc, st_seen, o_feedback_illegal, o_pair_effective, o_input_from_master,
        o_clock_cmd}, {(r == ROWS - 1) ? 6'h2D : 6'(RAM_BASE + r + 1), rows[r].st,
        rows[r].st[6] & rows[r].st[5], rows[r].st[7] ? rows[r].st[9:8] : i_status_pair,
        rows[r].st[3], rows[r].word[10] ? rows[r].word[21:11] : 11'h000});
    end
    // Loop count from the load word, mux setting from the final jump word
    check({o_loop_count, o_mux_setting}, {4'h5, 11'h0E8});
    $display("test done: program rows");
    // Serial key entry started by the last setup word
    wait_flag(1'b1, 12000);
    check(o_key_data, KEY);
    check({o_key_early, o_key_clock_fast, o_key_request}, 3'h0);
    $display("test done: serial key");
    // Status pair and port configuration reach the selectors
    i_status_pair = 2'h1;
    i_port_cfg_master = 1'b1;
    #1 check({o_pair_effective, o_input_from_master}, {2'h1, 1'b1});
    $display("test done: port selects");
    // Reset in mid-run, then a host write fills the input register
    @(posedge i_ref_clk);
    #1 i_reset_n = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1 i_reset_n = 1'b1;
    check({o_pc, st_seen}, {6'h00, 12'h001});
    write_req = 1'b1;
    @(posedge i_ref_clk);
    #1 write_req = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1 check(o_input_full, 1'b1);
    $display("test done: reset and host write");
    summarize();
  end
endmodule : testbench
